// >>> rtl/spd_cfg.svh
`ifndef SPD_CFG_SVH
`define SPD_CFG_SVH

// Coefficient RAM byte indices
`define SPD_IDX_PREFILT 4'h0
`define SPD_IDX_PEAK_SP 4'h1
`define SPD_IDX_PEAK_NS 4'h2
`define SPD_IDX_FLOOR 4'h3
`define SPD_IDX_RISE 4'h4
`define SPD_IDX_FALL 4'h5
`define SPD_IDX_CEIL 4'h6
`define SPD_IDX_MARGIN 4'h7
`define SPD_IDX_ECHO_GAIN 4'h8
`define SPD_IDX_RES_SP 4'h9
`define SPD_IDX_DEC_SP 4'hA
`define SPD_IDX_RES_NS 4'hB
`define SPD_IDX_DEC_NS 4'hC
`define SPD_IDX_HOLD 4'hD
`define SPD_IDX_LINE_ENH 4'hE
`define SPD_IDX_ATT 4'hF
`define SPD_COEFF_NUM 16

// Avalon byte addresses
`define SPD_ADDR_COEFF_TOP 8'h3C
`define SPD_ADDR_STATUS 8'h40
`define SPD_ADDR_LEVELS 8'h44

// Status field positions
`define SPD_ST_MODE_LSB 0
`define SPD_ST_TX_SPEECH 2
`define SPD_ST_RX_SPEECH 3
`define SPD_ST_PAIR_SPEECH 4

// Coefficient reset values
`define SPD_RST_PREFILT 8'h03
`define SPD_RST_PEAK_SP 8'hC8
`define SPD_RST_PEAK_NS 8'h08
`define SPD_RST_FLOOR 8'h88
`define SPD_RST_RISE 8'hFA
`define SPD_RST_FALL 8'h10
`define SPD_RST_CEIL 8'h3C
`define SPD_RST_MARGIN 8'h0C
`define SPD_RST_ECHO_GAIN 8'h00
`define SPD_RST_RES_SP 8'h18
`define SPD_RST_DEC_SP 8'h08
`define SPD_RST_RES_NS 8'h08
`define SPD_RST_DEC_NS 8'h04
`define SPD_RST_HOLD 8'h32
`define SPD_RST_LINE_ENH 8'h10
`define SPD_RST_ATT 8'h28

// Log scale: 8 codes per octave, full scale code
`define SPD_LOG_FULL 7'h7F
`define SPD_FLOOR_BASE 7'h30
`define SPD_FLOOR_STEP 7'h04

// Timing
`define SPD_SAMPLE_US 125
`define SPD_MS_US 1000
`define SPD_SMP_PER_MS (`SPD_MS_US / `SPD_SAMPLE_US)
`define SPD_HOLD_MS_PER_LSB 10'h004

`endif

// >>> rtl/spd_pkg.sv
package spd_pkg;
  typedef enum logic [1:0] {
    SPD_IDLE = 2'b00,
    SPD_TX = 2'b01,
    SPD_RX = 2'b10
  } spd_mode_type;
endpackage

// >>> rtl/spd_log.sv
`timescale 1ns/10ps
`include "spd_cfg.svh"
module spd_log (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_smp_stb,
  input wire logic signed [15:0] i_sample,
  input wire logic [7:0] i_prefilt,
  input wire logic [3:0] i_floor,
  output logic [6:0] o_raw,
  output logic [6:0] o_cmp
);
  logic [23:0] acc_q, acc_d;
  logic [6:0] raw_q, raw_d, cmp_q, cmp_d, floor_lvl;
  logic [15:0] mag;
  logic signed [24:0] diff;

  function automatic logic [6:0] spd_log2(input logic [15:0] v);
    logic [3:0] msb;
    logic [15:0] norm;
    msb = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (v[i]) begin
        msb = 4'(i);
      end
    end
    norm = v << (4'hF - msb);
    spd_log2 = (v == 16'h0000) ? 7'h00 : {msb, norm[14:12]};
  endfunction

  always_comb begin
    mag = i_sample[15] ? 16'(~i_sample + 16'h0001) : i_sample;
    // Spike prefilter ahead of the peak stage
    // one-pole low-pass
    diff = $signed({1'b0, mag, 8'h00}) - $signed({1'b0, acc_q});
    acc_d = acc_q;
    raw_d = raw_q;
    cmp_d = cmp_q;
    floor_lvl = `SPD_LOG_FULL - `SPD_FLOOR_BASE - 7'(i_floor) * `SPD_FLOOR_STEP;
    if (i_smp_stb) begin
      acc_d = 24'($signed({1'b0, acc_q}) + (diff >>> i_prefilt[3:0]));
      raw_d = spd_log2(acc_q[23:8]);
      cmp_d = (raw_d > floor_lvl) ? 7'(raw_d - floor_lvl) : 7'h00;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      acc_q <= 24'h000000;
      raw_q <= 7'h00;
      cmp_q <= 7'h00;
    end else begin
      acc_q <= acc_d;
      raw_q <= raw_d;
      cmp_q <= cmp_d;
    end
  end

  assign o_raw = raw_q;
  assign o_cmp = cmp_q;

  AST_FLOOR_CUT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_smp_stb && spd_log2(acc_q[23:8]) <= floor_lvl) |=> (o_cmp == 7'h00))
    else $error("Level below floor not cut to zero");
endmodule

// >>> rtl/spd_detector.sv
`timescale 1ns/10ps
module spd_detector (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_smp_stb,
  input wire logic [6:0] i_lvl,
  input wire logic [7:0] i_peak_speech_tc,
  input wire logic [7:0] i_peak_noise_tc,
  input wire logic [7:0] i_rise_tc,
  input wire logic [7:0] i_fall_tc,
  input wire logic [7:0] i_ceiling,
  input wire logic [7:0] i_margin,
  output logic o_speech
);
  logic [7:0] peak_q, peak_d, pcnt_q, pcnt_d, avg_q, avg_d, acnt_q, acnt_d;
  logic speech_q, speech_d;
  logic [7:0] ptc, atc;
  logic [8:0] thresh;

  always_comb begin
    peak_d = peak_q;
    pcnt_d = pcnt_q;
    avg_d = avg_q;
    acnt_d = acnt_q;
    speech_d = speech_q;
    ptc = speech_q ? i_peak_speech_tc : i_peak_noise_tc;
    atc = speech_q ? i_rise_tc : i_fall_tc;
    thresh = {1'b0, avg_q} + {1'b0, i_margin};
    if (i_smp_stb) begin
      if ({1'b0, i_lvl} >= peak_q) begin
        peak_d = {1'b0, i_lvl};
        pcnt_d = 8'h00;
      end else if (pcnt_q >= ptc) begin
        peak_d = peak_q - 8'h01;
        pcnt_d = 8'h00;
      end else begin
        pcnt_d = pcnt_q + 8'h01;
      end
      // frozen at the ceiling during speech while the peak is not below the average
      if (avg_q >= i_ceiling) begin
        if (!speech_q || peak_q < avg_q) begin
          avg_d = (avg_q > i_ceiling) ? i_ceiling : avg_q;
          if (peak_q < avg_q && acnt_q >= atc) begin
            avg_d = (i_ceiling != 8'h00) ? i_ceiling - 8'h01 : 8'h00;
          end
        end else begin
          avg_d = i_ceiling;
        end
        acnt_d = (acnt_q >= atc) ? 8'h00 : acnt_q + 8'h01;
      end else if (acnt_q >= atc) begin
        acnt_d = 8'h00;
        if (peak_q > avg_q) begin
          avg_d = avg_q + 8'h01;
        end else if (peak_q < avg_q) begin
          avg_d = avg_q - 8'h01;
        end
      end else begin
        acnt_d = acnt_q + 8'h01;
      end
      speech_d = {1'b0, peak_q} > thresh;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      peak_q <= 8'h00;
      pcnt_q <= 8'h00;
      avg_q <= 8'h00;
      acnt_q <= 8'h00;
      speech_q <= 1'b0;
    end else begin
      peak_q <= peak_d;
      pcnt_q <= pcnt_d;
      avg_q <= avg_d;
      acnt_q <= acnt_d;
      speech_q <= speech_d;
    end
  end

  assign o_speech = speech_q;

  AST_PEAK_TRACK: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_smp_stb && {1'b0, i_lvl} >= peak_q) |=> (peak_q == {1'b0, $past(i_lvl)}))
    else $error("Peak did not follow a larger level");
  AST_AVG_CEIL: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_smp_stb && $stable(i_ceiling)) |=> (avg_q <= i_ceiling))
    else $error("Noise average above its ceiling");
  AST_SPEECH_MARGIN: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_smp_stb && {1'b0, peak_q} <= {1'b0, avg_q} + {1'b0, i_margin}) |=> !o_speech)
    else $error("Speech flagged inside the margin");
endmodule

// >>> rtl/spd_top.sv
// Functional notes
// - Peak detector before noise monitor, separate speech and noise decay constants.
// - Programmable low-pass prefilter ahead of the peak detector removes spikes.
// - Floor byte: upper nibble transmit floor, lower nibble receive floor.
// - Levels compressed logarithmically above the floor, zero below it.
// - Noise average capped at a programmable ceiling above the floor.
// - Programmable margin between noise average and speech threshold.
// - Noise average uses a speech constant and a separate noise constant.
// - Active mode changes only while the matching detector shows speech.
// - Acoustic and line comparators run continuously toward the stronger direction.
// - In receive, go transmit when tx level beats rx plus acoustic enhancement.
// - Acoustic enhancement is echo gain plus a decaying reserve.
// - Comparator inputs are log compressed, compared as log levels.
// - Reserve decrements at a programmable rate after receive speech ends.
// - Two reserve and decrement pairs, for speech and for noise.
// - Switch to the noise pair after a programmable hold since speech end.
// - Echo gain is a signed decibel value.
// - Each parameter is one byte in the coefficient RAM.
// - Attenuation on rx in transmit, on tx in receive, halved in idle.
// - Noise average frozen at its ceiling during speech until a pause.
// - In transmit, go receive when rx beats tx plus line enhancement with rx speech.
`timescale 1ns/10ps
`include "spd_cfg.svh"
module spd_top (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_smp_stb,
  input wire logic signed [15:0] i_tx_sample,
  input wire logic signed [15:0] i_rx_sample,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic [1:0] o_mode,
  output logic o_tx_speech,
  output logic o_rx_speech,
  output logic [7:0] o_att_tx,
  output logic [7:0] o_att_rx
);
  logic [7:0] coeff_q [`SPD_COEFF_NUM];
  logic [7:0] coeff_d [`SPD_COEFF_NUM];
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic [6:0] raw [2];
  logic [6:0] cmp [2];
  logic [1:0] speech;
  logic [3:0] floor_nib [2];
  logic signed [15:0] samples [2];
  spd_pkg::spd_mode_type mode_q, mode_d;
  logic [7:0] reserve_q, reserve_d, dcnt_q, dcnt_d;
  logic pair_sp_q, pair_sp_d;
  logic [9:0] hold_q, hold_d, hold_target;
  logic [2:0] mscnt_q, mscnt_d;
  logic ms_tick;
  logic [7:0] att_tx_q, att_tx_d, att_rx_q, att_rx_d;
  logic signed [9:0] ae, rx_plus_ae, tx_plus_le;
  logic tx_wins, rx_wins;
  logic [7:0] res_sel, dec_sel;

  function automatic logic [7:0] spd_coeff_default(input int idx);
    case (idx)
      0: spd_coeff_default = `SPD_RST_PREFILT;
      1: spd_coeff_default = `SPD_RST_PEAK_SP;
      2: spd_coeff_default = `SPD_RST_PEAK_NS;
      3: spd_coeff_default = `SPD_RST_FLOOR;
      4: spd_coeff_default = `SPD_RST_RISE;
      5: spd_coeff_default = `SPD_RST_FALL;
      6: spd_coeff_default = `SPD_RST_CEIL;
      7: spd_coeff_default = `SPD_RST_MARGIN;
      8: spd_coeff_default = `SPD_RST_ECHO_GAIN;
      9: spd_coeff_default = `SPD_RST_RES_SP;
      10: spd_coeff_default = `SPD_RST_DEC_SP;
      11: spd_coeff_default = `SPD_RST_RES_NS;
      12: spd_coeff_default = `SPD_RST_DEC_NS;
      13: spd_coeff_default = `SPD_RST_HOLD;
      14: spd_coeff_default = `SPD_RST_LINE_ENH;
      default: spd_coeff_default = `SPD_RST_ATT;
    endcase
  endfunction

  function automatic logic spd_is_coeff(input logic [7:0] addr);
    spd_is_coeff = (addr[1:0] == 2'b00) && (addr <= `SPD_ADDR_COEFF_TOP);
  endfunction

  // Bus slave: one wait cycle per access
  always_comb begin
    ack_d = (i_avs_read || i_avs_write) && !ack_q;
    rdata_d = rdata_q;
    for (int i = 0; i < `SPD_COEFF_NUM; i++) begin
      coeff_d[i] = coeff_q[i];
    end
    if (i_avs_write && ack_q && i_avs_byteenable[0] && spd_is_coeff(i_avs_address)) begin
      coeff_d[i_avs_address[5:2]] = i_avs_writedata[7:0];
    end
    if (i_avs_read && !ack_q) begin
      rdata_d = 32'h00000000;
      if (spd_is_coeff(i_avs_address)) begin
        rdata_d[7:0] = coeff_q[i_avs_address[5:2]];
      end else if (i_avs_address == `SPD_ADDR_STATUS) begin
        rdata_d[`SPD_ST_MODE_LSB +: 2] = mode_q;
        rdata_d[`SPD_ST_TX_SPEECH] = speech[0];
        rdata_d[`SPD_ST_RX_SPEECH] = speech[1];
        rdata_d[`SPD_ST_PAIR_SPEECH] = pair_sp_q;
      end else if (i_avs_address == `SPD_ADDR_LEVELS) begin
        rdata_d[6:0] = raw[0];
        rdata_d[14:8] = raw[1];
        rdata_d[23:16] = reserve_q;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
      for (int i = 0; i < `SPD_COEFF_NUM; i++) begin
        coeff_q[i] <= spd_coeff_default(i);
      end
    end else begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      for (int i = 0; i < `SPD_COEFF_NUM; i++) begin
        coeff_q[i] <= coeff_d[i];
      end
    end
  end

  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_q;
  assign o_avs_readdata = rdata_q;

  // nibble split of the floor byte
  assign floor_nib[0] = coeff_q[`SPD_IDX_FLOOR][7:4];
  assign floor_nib[1] = coeff_q[`SPD_IDX_FLOOR][3:0];
  assign samples[0] = i_tx_sample;
  assign samples[1] = i_rx_sample;

  // Index 0 transmit path, 1 receive path
  for (genvar g = 0; g < 2; g++) begin : g_path
    spd_log u_log (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_smp_stb(i_smp_stb),
      .i_sample(samples[g]),
      .i_prefilt(coeff_q[`SPD_IDX_PREFILT]),
      .i_floor(floor_nib[g]),
      .o_raw(raw[g]),
      .o_cmp(cmp[g])
    );
    spd_detector u_det (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_smp_stb(i_smp_stb),
      .i_lvl(cmp[g]),
      .i_peak_speech_tc(coeff_q[`SPD_IDX_PEAK_SP]),
      .i_peak_noise_tc(coeff_q[`SPD_IDX_PEAK_NS]),
      .i_rise_tc(coeff_q[`SPD_IDX_RISE]),
      .i_fall_tc(coeff_q[`SPD_IDX_FALL]),
      .i_ceiling(coeff_q[`SPD_IDX_CEIL]),
      .i_margin(coeff_q[`SPD_IDX_MARGIN]),
      .o_speech(speech[g])
    );
  end

  // Comparators on log levels
  always_comb begin
    ae = 10'(signed'(coeff_q[`SPD_IDX_ECHO_GAIN])) + $signed({2'b00, reserve_q});
    rx_plus_ae = $signed({3'b000, raw[1]}) + ae;
    tx_plus_le = $signed({3'b000, raw[0]}) + $signed({2'b00, coeff_q[`SPD_IDX_LINE_ENH]});
    tx_wins = speech[0] && ($signed({3'b000, raw[0]}) > rx_plus_ae);
    rx_wins = speech[1] && ($signed({3'b000, raw[1]}) > tx_plus_le);
  end

  // Reserve, pair selection and hold timer
  always_comb begin
    ms_tick = i_smp_stb && (mscnt_q == 3'(`SPD_SMP_PER_MS - 1));
    mscnt_d = mscnt_q;
    if (i_smp_stb) begin
      mscnt_d = ms_tick ? 3'h0 : mscnt_q + 3'h1;
    end
    res_sel = pair_sp_q ? coeff_q[`SPD_IDX_RES_SP] : coeff_q[`SPD_IDX_RES_NS];
    dec_sel = pair_sp_q ? coeff_q[`SPD_IDX_DEC_SP] : coeff_q[`SPD_IDX_DEC_NS];
    hold_target = 10'(coeff_q[`SPD_IDX_HOLD]) * `SPD_HOLD_MS_PER_LSB;
    reserve_d = reserve_q;
    dcnt_d = dcnt_q;
    pair_sp_d = pair_sp_q;
    hold_d = hold_q;
    if (speech[1]) begin
      pair_sp_d = 1'b1;
      hold_d = 10'h000;
    end else if (pair_sp_q) begin
      if (hold_q >= hold_target) begin
        pair_sp_d = 1'b0;
      end else if (ms_tick) begin
        hold_d = hold_q + 10'h001;
      end
    end
    if (i_smp_stb) begin
      if (speech[1]) begin
        reserve_d = res_sel;
        dcnt_d = 8'h00;
      end else if (dcnt_q >= dec_sel) begin
        dcnt_d = 8'h00;
        reserve_d = (reserve_q != 8'h00) ? reserve_q - 8'h01 : 8'h00;
      end else begin
        dcnt_d = dcnt_q + 8'h01;
      end
    end
  end

  // Mode decision, stepped on the sample strobe
  always_comb begin
    mode_d = mode_q;
    if (i_smp_stb) begin
      case (mode_q)
        spd_pkg::SPD_IDLE: begin
          if (tx_wins) begin
            mode_d = spd_pkg::SPD_TX;
          end else if (rx_wins) begin
            mode_d = spd_pkg::SPD_RX;
          end
        end
        spd_pkg::SPD_RX: begin
          if (tx_wins) begin
            mode_d = spd_pkg::SPD_TX;
          end else if (!speech[0] && !speech[1]) begin
            mode_d = spd_pkg::SPD_IDLE;
          end
        end
        spd_pkg::SPD_TX: begin
          if (rx_wins) begin
            mode_d = spd_pkg::SPD_RX;
          end else if (!speech[0] && !speech[1]) begin
            mode_d = spd_pkg::SPD_IDLE;
          end
        end
        default: mode_d = spd_pkg::SPD_IDLE;
      endcase
    end
    case (mode_q)
      spd_pkg::SPD_TX: begin
        att_tx_d = 8'h00;
        att_rx_d = coeff_q[`SPD_IDX_ATT];
      end
      spd_pkg::SPD_RX: begin
        att_tx_d = coeff_q[`SPD_IDX_ATT];
        att_rx_d = 8'h00;
      end
      default: begin
        att_tx_d = coeff_q[`SPD_IDX_ATT] >> 1;
        att_rx_d = coeff_q[`SPD_IDX_ATT] >> 1;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      mode_q <= spd_pkg::SPD_IDLE;
      reserve_q <= 8'h00;
      dcnt_q <= 8'h00;
      pair_sp_q <= 1'b0;
      hold_q <= 10'h000;
      mscnt_q <= 3'h0;
      att_tx_q <= 8'h00;
      att_rx_q <= 8'h00;
    end else begin
      mode_q <= mode_d;
      reserve_q <= reserve_d;
      dcnt_q <= dcnt_d;
      pair_sp_q <= pair_sp_d;
      hold_q <= hold_d;
      mscnt_q <= mscnt_d;
      att_tx_q <= att_tx_d;
      att_rx_q <= att_rx_d;
    end
  end

  assign o_mode = mode_q;
  assign o_tx_speech = speech[0];
  assign o_rx_speech = speech[1];
  assign o_att_tx = att_tx_q;
  assign o_att_rx = att_rx_q;

  AST_RX_TO_TX: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_smp_stb && mode_q == spd_pkg::SPD_RX && tx_wins) |=> (mode_q == spd_pkg::SPD_TX))
    else $error("Receive did not yield to stronger transmit");
  AST_NO_SWITCH_SILENT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (mode_q == spd_pkg::SPD_RX && !speech[0]) |=> (mode_q != spd_pkg::SPD_TX))
    else $error("Switched to transmit without transmit speech");
  AST_TX_TO_RX: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_smp_stb && mode_q == spd_pkg::SPD_TX && rx_wins) |=> (mode_q == spd_pkg::SPD_RX))
    else $error("Transmit did not yield to stronger receive");
  AST_RESERVE_FALLS: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!speech[1]) |=> (reserve_q <= $past(reserve_q) && {1'b0, reserve_q} + 9'h001 >= {1'b0, $past(reserve_q)}))
    else $error("Reserve rose or fell by more than one step");
  AST_ATT_IN_TX: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (mode_q == spd_pkg::SPD_TX) ##1 (mode_q == spd_pkg::SPD_TX) |-> (o_att_tx == 8'h00))
    else $error("Transmit path attenuated in transmit mode");
  AST_HOLD_PAIR: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $fell(pair_sp_q) |-> ($past(hold_q) >= $past(hold_target) && !$past(speech[1])))
    else $error("Noise pair taken before the hold time");
  AST_BUS_ONE_WAIT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ($rose(i_avs_read) && !ack_q) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
    else $error("Bus answer not after exactly one wait cycle");
endmodule

// >>> sim/spd_audio_src.sv
`timescale 1ns/10ps
module spd_audio_src #(
  parameter int PERIOD = 16
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [14:0] i_tx_amp,
  input wire logic [14:0] i_rx_amp,
  output logic o_smp_stb,
  output logic signed [15:0] o_tx_sample,
  output logic signed [15:0] o_rx_sample
);
  int cnt;
  logic sgn;
  // one strobe per period
  // Both paths change together, square wave of the given amplitude
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cnt <= 0;
      sgn <= 1'b0;
      o_smp_stb <= 1'b0;
      o_tx_sample <= 16'sh0000;
      o_rx_sample <= 16'sh0000;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      o_smp_stb <= (cnt == PERIOD - 1);
      if (cnt == PERIOD - 1) begin
        sgn <= ~sgn;
        o_tx_sample <= sgn ? -$signed({1'b0, i_tx_amp}) : $signed({1'b0, i_tx_amp});
        o_rx_sample <= sgn ? -$signed({1'b0, i_rx_amp}) : $signed({1'b0, i_rx_amp});
      end
    end
  end
endmodule

// >>> sim/speech_detect_acoustic_compare_bench.sv
`timescale 1ns/10ps
module speech_detect_acoustic_compare_bench;
  logic i_clk, i_sys_rst, i_smp_stb, i_avs_read, i_avs_write, o_avs_waitrequest, o_tx_speech, o_rx_speech;
  logic signed [15:0] i_tx_sample, i_rx_sample;
  logic [7:0] i_avs_address, o_att_tx, o_att_rx;
  logic [31:0] i_avs_writedata, o_avs_readdata, q;
  logic [3:0] i_avs_byteenable, hist;
  logic [1:0] o_mode, prev_mode, prev_flags;
  logic [14:0] tx_amp, rx_amp;
  int bad_count, comparisons, cycles, ready, seed, saw_tx, r;
  int regs[16];
  int defs[16] = '{'h03, 'hC8, 'h08, 'h88, 'hFA, 'h10, 'h3C, 'h0C, 'h00, 'h18, 'h08, 'h08, 'h04, 'h32, 'h10, 'h28};
  int prog[16] = '{'h00, 'h01, 'h01, 'h0F, 'hFA, 'h01, 'h3C, 'h0C, 'h30, 'h00, 'h01, 'h00, 'h01, 'h00, 'h10, 'h28};
  spd_audio_src #(.PERIOD(16)) src (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_tx_amp(tx_amp), .i_rx_amp(rx_amp),
    .o_smp_stb(i_smp_stb), .o_tx_sample(i_tx_sample), .o_rx_sample(i_rx_sample));
  spd_top dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_smp_stb(i_smp_stb), .i_tx_sample(i_tx_sample),
    .i_rx_sample(i_rx_sample), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .o_mode(o_mode), .o_tx_speech(o_tx_speech), .o_rx_speech(o_rx_speech),
    .o_att_tx(o_att_tx), .o_att_rx(o_att_rx));
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  task automatic end_of_test();
    $display("Mismatches %0d of %0d comparisons", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge i_clk);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_byteenable <= be;
    i_avs_write <= wr;
    i_avs_read <= ~wr;
    @(posedge i_clk iff o_avs_waitrequest === 1'b0);
    q = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  endtask
  task automatic wait_stb(input int n);
    repeat (n) @(posedge i_clk iff i_smp_stb === 1'b1);
  endtask
  task automatic wait_mode(input logic [1:0] m, input int n);
    while (o_mode !== m && n > 0) begin
      wait_stb(1);
      n--;
    end
    repeat (4) @(posedge i_clk);
  endtask
  // Timeout cut-off
  always @(posedge i_clk) begin
    cycles++;
    if (cycles > 90000) begin
      bad_count++;
      end_of_test();
    end
  end
  // Attenuation and mode monitor
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      ready = 0;
    end else begin
      ready++;
      if (ready > 3) begin
        chk({o_att_tx, o_att_rx}, prev_mode === spd_pkg::SPD_TX ? {8'h00, 8'(regs[15])} :
          prev_mode === spd_pkg::SPD_RX ? {8'(regs[15]), 8'h00} : {2{8'(regs[15] / 2)}});
        // Mode entry judged on the flags the decision saw
        if (o_mode !== prev_mode && o_mode === spd_pkg::SPD_TX) chk(prev_flags[1], 1'b1);
        if (o_mode !== prev_mode && o_mode === spd_pkg::SPD_RX) chk(prev_flags[0], 1'b1);
        if (o_mode === spd_pkg::SPD_TX) saw_tx = 1;
        // Flags may only move after a strobe edge
        if (hist[0] !== 1'b1 && ready > 5) chk({o_tx_speech, o_rx_speech}, prev_flags);
      end
      hist = {hist[2:0], i_smp_stb};
      prev_mode = o_mode;
      prev_flags = {o_tx_speech, o_rx_speech};
    end
  end
  initial begin
    {i_avs_read, i_avs_write, i_avs_address, i_avs_writedata, i_avs_byteenable, tx_amp, rx_amp} = '0;
    {bad_count, comparisons, cycles, saw_tx} = '0;
    hist = 4'h0;
    prev_mode = 2'b00;
    prev_flags = 2'b00;
    seed = 27270;
    regs = defs;
    i_sys_rst = 1'b1;
    repeat (12) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      xfer(1'b0, 8'(i * 4), 32'h0, 4'hF);
      chk(q, 32'(defs[i]));
    end
    xfer(1'b0, 8'h40, 32'h0, 4'hF);
    chk(q[3:0], 4'h0);
    xfer(1'b1, 8'h80, 32'h55, 4'hF);
    xfer(1'b0, 8'h80, 32'h0, 4'hF);
    chk(q, 32'h0);
    $display("Test 1 done");
    for (int i = 0; i < 15; i++) begin
      r = $random(seed) & 'hFF;
      xfer(1'b1, 8'(i * 4), 32'(r), 4'hF);
      xfer(1'b1, 8'(i * 4), 32'(r ^ 'hFF), 4'h0);
      xfer(1'b0, 8'(i * 4), 32'h0, 4'hF);
      chk(q, 32'(r));
      xfer(1'b1, 8'(i * 4), 32'(prog[i]), 4'h1);
    end
    regs = prog;
    $display("Test 2 done");
    tx_amp <= 15'h0040;
    rx_amp <= 15'h0040;
    wait_stb(40);
    xfer(1'b0, 8'h44, 32'h0, 4'hF);
    chk(q[6:0], 7'h30);
    chk(q[14:8], 7'h30);
    xfer(1'b0, 8'h40, 32'h0, 4'hF);
    chk(q[3:2], 2'b10);
    rx_amp <= 15'h0000;
    tx_amp <= 15'h0000;
    wait_stb(40);
    xfer(1'b0, 8'h44, 32'h0, 4'hF);
    chk(q[14:0], 15'h0000);
    wait_mode(spd_pkg::SPD_IDLE, 600);
    $display("Test 3 done");
    rx_amp <= 15'h3E80;
    wait_mode(spd_pkg::SPD_RX, 400);
    chk(o_mode, spd_pkg::SPD_RX);
    saw_tx = 0;
    tx_amp <= 15'h3E80;
    wait_stb(200);
    chk(saw_tx, 0);
    xfer(1'b1, 8'h20, 32'hD0, 4'h1);
    wait_mode(spd_pkg::SPD_TX, 200);
    chk(o_mode, spd_pkg::SPD_TX);
    // Louder receive over zero line enhancement
    xfer(1'b1, 8'h20, 32'h30, 4'h1);
    xfer(1'b1, 8'h38, 32'h00, 4'h1);
    rx_amp <= 15'h7FFF;
    wait_mode(spd_pkg::SPD_RX, 200);
    chk(o_mode, spd_pkg::SPD_RX);
    $display("Test 4 done");
    tx_amp <= 15'h0000;
    rx_amp <= 15'h0000;
    wait_mode(spd_pkg::SPD_IDLE, 600);
    chk(o_mode, spd_pkg::SPD_IDLE);
    // Reserve pairs, hold of 4 ms is 32 samples
    xfer(1'b1, 8'h20, 32'h30, 4'h1);
    xfer(1'b1, 8'h24, 32'h18, 4'h1);
    xfer(1'b1, 8'h2C, 32'h08, 4'h1);
    xfer(1'b1, 8'h34, 32'h01, 4'h1);
    rx_amp <= 15'h3E80;
    wait_stb(20);
    xfer(1'b0, 8'h44, 32'h0, 4'hF);
    chk(q[23:16], 8'h18);
    rx_amp <= 15'h0000;
    r = 600;
    while (o_rx_speech !== 1'b0 && r > 0) begin
      wait_stb(1);
      r--;
    end
    wait_stb(10);
    xfer(1'b0, 8'h44, 32'h0, 4'hF);
    chk(q[23:16] < 8'h18, 1'b1);
    xfer(1'b0, 8'h40, 32'h0, 4'hF);
    chk(q[4], 1'b1);
    wait_stb(60);
    xfer(1'b0, 8'h40, 32'h0, 4'hF);
    chk(q[4], 1'b0);
    $display("Test 5 done");
    end_of_test();
  end
endmodule
